// ===== src/acmof_pkg.sv
// Shared constants and types for the accelerometer mode and output formatting block
package acmof_pkg;
    // Power states; OFF and BOOT report as standby in the state field
    typedef enum logic [2:0] {
        ACMOF_OFF   = 3'b000,
        ACMOF_BOOT  = 3'b001,
        ACMOF_STBY  = 3'b010,
        ACMOF_WAKE  = 3'b011,
        ACMOF_SLEEP = 3'b100
    } acmof_pwr_e;

    // System state field encodings
    localparam logic [1:0] SYSF_STBY = 2'h0;
    localparam logic [1:0] SYSF_WAKE = 2'h1;
    localparam logic [1:0] SYSF_SLEEP = 2'h2;

    // Full-scale selection codes; the code equals the right shift applied
    localparam logic [1:0] FS_2G = 2'h0;
    localparam logic [1:0] FS_4G = 2'h1;
    localparam logic [1:0] FS_8G = 2'h2;
    localparam int SENS_2G = 256;
    localparam int SENS_4G = 128;
    localparam int SENS_8G = 64;
    // Raw front-end data is at 2 g sensitivity
    localparam logic [1:0] SHIFT_8G = 2'h2;

    // Widths and counts
    localparam int RAW_W = 14;
    localparam int OUT_W = 10;
    localparam int TRIM_W = 16;
    localparam int N_AXES = 3;
    localparam int UOFF_REGS = 6;
    localparam logic [1:0] NVM_LAST = 2'h2;

    // Field positions inside the output byte pair
    localparam int MSB_LO_BIT = 2;
    localparam int LSB_FILL_W = 6;

    // Values after reset
    localparam logic [7:0] OUT_BYTE_RST = 8'h00;
    localparam logic [7:0] UOFF_RST = 8'h00;
    localparam logic [TRIM_W-1:0] TRIM_RST = 16'h0000;
endpackage

// ===== src/acmof_axis_fmt.sv
// One axis: offset correction, full-scale scaling and 10-bit saturation
`timescale 1ns/1ps
`default_nettype none
module acmof_axis_fmt #(
    parameter int RAW_W = 14,
    parameter int OUT_W = 10,
    parameter int TRIM_W = 16
) (
    // Raw sample at 2 g sensitivity
    input wire logic [RAW_W-1:0] raw,
    // Factory trim and user offset, both signed counts at 2 g sensitivity
    input wire logic [TRIM_W-1:0] trim,
    input wire logic [TRIM_W-1:0] user_off,
    // Full-scale code
    input wire logic [1:0] range,
    // Two's-complement result
    output logic [OUT_W-1:0] sample
);
    import acmof_pkg::*;

    localparam int SUM_W = TRIM_W + 2;
    localparam logic signed [SUM_W-1:0] SAT_HI = SUM_W'((2 ** (OUT_W - 1)) - 1);
    localparam logic signed [SUM_W-1:0] SAT_LO = -SAT_HI - SUM_W'(1);

    // Sum must not be narrower than the raw input
    if (RAW_W > TRIM_W || OUT_W > TRIM_W || OUT_W < 8) begin : g_bad_width
        $error("acmof_axis_fmt: unsupported width combination");
    end

    logic signed [SUM_W-1:0] sum;
    logic signed [SUM_W-1:0] scaled;
    logic [1:0] shift;

    // Offset, scale, then clip so the range ends one count below +full scale
    always_comb begin
        sum = $signed({{(SUM_W-RAW_W){raw[RAW_W-1]}}, raw})
            + $signed({{2{trim[TRIM_W-1]}}, trim})
            + $signed({{2{user_off[TRIM_W-1]}}, user_off});
        shift = (range > SHIFT_8G) ? SHIFT_8G : range; // Reserved code acts as 8 g
        scaled = sum >>> shift;
        if (scaled > SAT_HI) begin
            sample = SAT_HI[OUT_W-1:0];
        end else if (scaled < SAT_LO) begin
            sample = SAT_LO[OUT_W-1:0];
        end else begin
            sample = scaled[OUT_W-1:0];
        end
    end
endmodule // acmof_axis_fmt
`default_nettype wire

// ===== src/acmof_core.sv
// Power-state control, trim loading and output formatting of a three-axis accelerometer
// Overview of operation
// - Scaling is 256 counts/g at 2 g, 128 at 4 g and 64 at 8 g.
// - Each axis is a signed 10-bit value split over a high and a low byte.
// - The high byte holds the eight most significant bits of the sample.
// - With fast read set only the high bytes carry data; clearing it restores 10 bits.
// - At 2 g the range is -2 g to +1.9961 g, one count being 1/256 g.
// - At 8 g the range reaches +7.9844 g, one count being 1/64 g.
// - The 8-bit high-byte result has a quarter of the full resolution.
// - Standby keeps digital logic only, analog and sampling stopped, registers writable.
// - Off shuts everything down and the serial interface answers nothing.
// - Active (wake or sleep) enables all blocks and serial access.
// - Active to standby leaves every register unchanged.
// - Standby to active resets the output data registers and keeps all others.
// - Sleep and wake are sub-states of active.
// - At power-up the trim values are fetched from nonvolatile storage before use.
// - Six volatile host-writable offset registers adjust per-axis zero-g offset.
// - The serial slave never holds the clock line low.
`timescale 1ns/1ps
`default_nettype none
module acmof_core #(
    parameter int RAW_W = acmof_pkg::RAW_W
) (
    // System clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Supply monitor pin
    input wire logic supply_ok_pin,
    // Control bits from control_one_register and the auto-sleep engine
    input wire logic active_req,
    input wire logic sleep_req,
    input wire logic fast_read,
    input wire logic [1:0] full_scale,
    // Nonvolatile trim store
    output logic nvm_rd_q,
    output logic [1:0] nvm_addr_q,
    input wire logic nvm_ack,
    input wire logic [acmof_pkg::TRIM_W-1:0] nvm_data,
    // User offset byte writes
    input wire logic uoff_wr,
    input wire logic [2:0] uoff_idx,
    input wire logic [7:0] uoff_data,
    // Link from the analog front end
    input wire logic adc_clk,
    input wire logic adc_valid,
    input wire logic [acmof_pkg::N_AXES*RAW_W-1:0] adc_data,
    output logic adc_ready_q,
    // Formatted output bytes, axis 0 in the low byte
    output logic [acmof_pkg::N_AXES*8-1:0] out_msb_q,
    output logic [acmof_pkg::N_AXES*8-1:0] out_lsb_q,
    output logic data_ready_q,
    // Status and pin controls
    output logic [1:0] system_state_field_q,
    output logic bus_enable_q,
    output logic analog_en_q,
    output logic scl_oe_q
);
    import acmof_pkg::*;

    if (RAW_W < 8 || RAW_W > TRIM_W) begin : g_bad_raw
        $error("acmof_core: RAW_W out of supported range");
    end

    typedef struct packed {
        logic [1:0] pwr_sync;
        logic [2:0] req_sync;
        logic ack;
        acmof_pwr_e st;
        logic nvm_rd;
        logic [1:0] nvm_idx;
        logic [N_AXES-1:0][TRIM_W-1:0] trim;
        logic [UOFF_REGS-1:0][7:0] uoff;
        logic [N_AXES-1:0][7:0] msb;
        logic [N_AXES-1:0][7:0] lsb;
        logic drdy;
        logic [1:0] sysf;
        logic bus_en;
        logic ana_en;
        logic scl_oe;
    } acmof_core_s;

    typedef struct packed {
        logic [1:0] en_sync;
        logic [1:0] ack_sync;
        logic req;
        logic rdy;
        logic [N_AXES*RAW_W-1:0] hold;
    } acmof_link_s;

    acmof_core_s core_q;
    acmof_core_s core_d;
    acmof_link_s link_q;
    acmof_link_s link_d;
    logic [N_AXES-1:0][OUT_W-1:0] fmt_sample;
    logic sample_edge;
    logic pwr_ok;

    assign pwr_ok = core_q.pwr_sync[1];
    assign sample_edge = core_q.req_sync[1] ^ core_q.req_sync[2];

    // One formatter per axis, fed from the link hold register
    for (genvar a = 0; a < N_AXES; a++) begin : g_axis
        acmof_axis_fmt #(
            .RAW_W(RAW_W),
            .OUT_W(OUT_W),
            .TRIM_W(TRIM_W)
        ) u_fmt (
            .raw(link_q.hold[a*RAW_W +: RAW_W]),
            .trim(core_q.trim[a]),
            .user_off({core_q.uoff[2*a+1], core_q.uoff[2*a]}),
            .range(full_scale),
            .sample(fmt_sample[a])
        );
    end

    // Link side: capture one sample, hold it until the core acknowledges
    always_comb begin
        logic busy;
        logic take;
        link_d = link_q;
        busy = link_q.req != link_q.ack_sync[1];
        take = adc_valid && link_q.rdy;
        link_d.en_sync = {link_q.en_sync[0], core_q.ana_en};
        link_d.ack_sync = {link_q.ack_sync[0], core_q.ack};
        if (take) begin
            link_d.hold = adc_data;
            link_d.req = ~link_q.req;
        end
        // Held data must stay stable while the toggle crosses over
        link_d.rdy = link_q.en_sync[1] && !busy && !take;
    end

    always_ff @(posedge adc_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link_q <= '0;
        end else begin
            link_q <= link_d;
        end
    end

    // Core side: power states, trim fetch, offsets and output registers
    always_comb begin
        core_d = core_q;
        core_d.pwr_sync = {core_q.pwr_sync[0], supply_ok_pin};
        core_d.req_sync = {core_q.req_sync[1:0], link_q.req};
        core_d.ack = core_q.req_sync[1]; // Always acknowledge so the link never stalls
        case (core_q.st)
            ACMOF_OFF: begin
                core_d.nvm_idx = 2'h0;
                if (pwr_ok) begin
                    core_d.st = ACMOF_BOOT;
                end
            end
            ACMOF_BOOT: begin
                // Trim words are fetched one by one before standby is reached
                if (nvm_ack && core_q.nvm_rd) begin
                    core_d.trim[core_q.nvm_idx] = nvm_data;
                    core_d.nvm_idx = core_q.nvm_idx + 2'h1;
                    if (core_q.nvm_idx == NVM_LAST) begin
                        core_d.st = ACMOF_STBY;
                    end
                end
            end
            ACMOF_STBY: begin
                if (active_req) begin
                    core_d.st = ACMOF_WAKE;
                    core_d.msb = '0;
                    core_d.lsb = '0;
                    core_d.drdy = 1'b0;
                end
            end
            ACMOF_WAKE: begin
                if (!active_req) begin
                    core_d.st = ACMOF_STBY;
                end else if (sleep_req) begin
                    core_d.st = ACMOF_SLEEP;
                end
            end
            ACMOF_SLEEP: begin
                if (!active_req) begin
                    core_d.st = ACMOF_STBY;
                end else if (!sleep_req) begin
                    core_d.st = ACMOF_WAKE;
                end
            end
            default: begin
                core_d.st = ACMOF_OFF;
            end
        endcase
        core_d.nvm_rd = (core_d.st == ACMOF_BOOT);
        // Samples are taken only while active; in standby they are dropped
        core_d.drdy = core_d.drdy && !sample_edge;
        if (sample_edge && (core_q.st == ACMOF_WAKE || core_q.st == ACMOF_SLEEP)) begin
            for (int a = 0; a < N_AXES; a++) begin
                core_d.msb[a] = fmt_sample[a][OUT_W-1:MSB_LO_BIT];
                core_d.lsb[a] = fast_read ? OUT_BYTE_RST
                    : {fmt_sample[a][MSB_LO_BIT-1:0], LSB_FILL_W'(0)};
            end
            core_d.drdy = 1'b1;
        end
        // Offset writes are taken whenever the serial interface is alive
        if (uoff_wr && core_q.bus_en && uoff_idx < 3'(UOFF_REGS)) begin
            core_d.uoff[uoff_idx] = uoff_data;
        end
        // Loss of supply wipes every volatile register
        if (!pwr_ok) begin
            core_d = '0;
            core_d.pwr_sync = {core_q.pwr_sync[0], supply_ok_pin};
            core_d.req_sync = {core_q.req_sync[1:0], link_q.req};
            core_d.ack = core_q.req_sync[1];
            core_d.st = ACMOF_OFF;
        end
        core_d.bus_en = (core_d.st != ACMOF_OFF && core_d.st != ACMOF_BOOT);
        core_d.ana_en = (core_d.st == ACMOF_WAKE || core_d.st == ACMOF_SLEEP);
        core_d.sysf = (core_d.st == ACMOF_WAKE) ? SYSF_WAKE
            : (core_d.st == ACMOF_SLEEP) ? SYSF_SLEEP : SYSF_STBY;
        core_d.scl_oe = 1'b0; // Slave never drives the clock line
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_q <= '0;
        end else begin
            core_q <= core_d;
        end
    end

    // Ports straight from flip-flops
    assign adc_ready_q = link_q.rdy;
    assign nvm_rd_q = core_q.nvm_rd;
    assign nvm_addr_q = core_q.nvm_idx;
    assign out_msb_q = core_q.msb;
    assign out_lsb_q = core_q.lsb;
    assign data_ready_q = core_q.drdy;
    assign system_state_field_q = core_q.sysf;
    assign bus_enable_q = core_q.bus_en;
    assign analog_en_q = core_q.ana_en;
    assign scl_oe_q = core_q.scl_oe;

    // Checks on the system clock domain, except link_hold_a on adc_clk
    default clocking cb_ref @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence active_seen;
        core_q.st == ACMOF_WAKE || core_q.st == ACMOF_SLEEP;
    endsequence

    // A host write or a sample landing on the leaving edge is legal traffic, not a loss
    sequence stby_entry;
        (active_seen and (!sample_edge && !uoff_wr)) ##1 core_q.st == ACMOF_STBY;
    endsequence

    sequence wake_entry;
        core_q.st == ACMOF_STBY && active_req && pwr_ok && !uoff_wr;
    endsequence

    // Reference sum for axis 2, widened so the clip point is visible
    logic signed [TRIM_W+1:0] chk_sum2;
    assign chk_sum2 = (TRIM_W+2)'($signed(link_q.hold[2*RAW_W +: RAW_W]))
        + (TRIM_W+2)'($signed(core_q.trim[2]))
        + (TRIM_W+2)'($signed({core_q.uoff[5], core_q.uoff[4]}));

    off_bus_quiet_a: assert property (
        core_q.st == ACMOF_OFF |-> ##1 !bus_enable_q
    ) else $error("serial interface enabled while off");

    no_clock_stretch_a: assert property (
        !scl_oe_q
    ) else $error("clock line driven by slave");

    active_blocks_a: assert property (
        active_seen |-> analog_en_q && bus_enable_q
    ) else $error("active state without analog or bus enable");

    stby_analog_off_a: assert property (
        core_q.st == ACMOF_STBY && $past(core_q.st) == ACMOF_STBY |-> !analog_en_q
    ) else $error("analog section on in standby");

    stby_retain_a: assert property (
        stby_entry |-> $stable(out_msb_q) && $stable(out_lsb_q)
            && $stable(core_q.uoff) && $stable(core_q.trim)
    ) else $error("registers changed entering standby");

    wake_clear_a: assert property (
        wake_entry |=> out_msb_q == '0 && out_lsb_q == '0 && core_q.uoff == $past(core_q.uoff)
    ) else $error("output registers not reset on wake");

    msb_split_a: assert property (
        (active_seen and (sample_edge && pwr_ok))
            |=> out_msb_q[7:0] == $past(fmt_sample[0][OUT_W-1:MSB_LO_BIT])
    ) else $error("high byte does not hold the top eight bits");

    fast_read_lsb_a: assert property (
        (active_seen and (sample_edge && pwr_ok && fast_read))
            |=> out_lsb_q == '0 ##0 data_ready_q
    ) else $error("low bytes carry data in fast read");

    full_read_lsb_a: assert property (
        (active_seen and (sample_edge && pwr_ok && !fast_read))
            |=> out_lsb_q[7:6] == $past(fmt_sample[0][1:0]) && out_lsb_q[5:0] == '0
    ) else $error("low byte does not hold the two least bits");

    state_field_a: assert property (
        core_q.st == ACMOF_SLEEP |-> system_state_field_q == SYSF_SLEEP
    ) else $error("state field does not show sleep");

    trim_before_use_a: assert property (
        core_q.st == ACMOF_BOOT && nvm_ack && core_q.nvm_idx == NVM_LAST && pwr_ok
            |=> core_q.st == ACMOF_STBY && core_q.trim[NVM_LAST] == $past(nvm_data)
    ) else $error("trim not loaded on boot");

    uoff_write_a: assert property (
        uoff_wr && bus_enable_q && uoff_idx < 3'(UOFF_REGS) && pwr_ok
            |=> core_q.uoff[$past(uoff_idx)] == $past(uoff_data)
    ) else $error("offset register write lost");

    range_2g_a: assert property (
        full_scale == FS_2G && chk_sum2 > 18'sh001FF |-> fmt_sample[2] == 10'h1FF
    ) else $error("2 g sample outside range");

    link_hold_a: assert property (
        @(posedge adc_clk) disable iff (sys_rst)
        link_q.req != link_q.ack_sync[1] |=> $stable(link_q.hold)
    ) else $error("held sample changed before acknowledge");
endmodule // acmof_core
`default_nettype wire

// ===== dv/acmof_fe_model.sv
// Behavioural analog front end offering three-axis samples over the link
`timescale 1ns/1ps
`default_nettype none
module acmof_fe_model (
    // Bench request side
    input wire logic send,
    input wire logic [41:0] sample,
    output logic sent,
    output logic took,
    // Link side
    output logic adc_clk,
    output logic adc_valid,
    output logic [41:0] adc_data,
    input wire logic adc_ready_q
);
    int n;
    logic tk;
    // One frame per request; the link clock stands still between frames
    initial begin
        {sent, took, adc_clk, adc_valid, adc_data} = '0;
        #3;
        forever begin
            wait (send === 1'b1);
            took = 1'b0;
            adc_valid = 1'b1;
            adc_data = sample;
            // Gives up after 16 cycles so a refusing core cannot hang us
            for (n = 0; n < 16; n++) begin
                #80;
                tk = adc_valid & (adc_ready_q === 1'b1);
                adc_clk = 1'b1;
                #1;
                if (tk) begin
                    took = 1'b1;
                    adc_valid = 1'b0;
                    n = (n < 11) ? 11 : n; // Four more edges carry the ack home
                end
                #79 adc_clk = 1'b0;
            end
            // Released data must not keep looking like the sample
            adc_valid = 1'b0;
            adc_data = ~sample;
            sent = 1'b1;
            wait (send === 1'b0);
            sent = 1'b0;
        end
    end
endmodule // acmof_fe_model
`default_nettype wire

// ===== dv/test_accel_mode_and_output_format.sv
// Self-checking bench for the power-state and output formatting core
`timescale 1ns/1ps
`default_nettype none
module test_accel_mode_and_output_format;
    import acmof_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic supply_ok_pin = 1'b0;
    logic active_req = 1'b0;
    logic sleep_req = 1'b0;
    logic fast_read = 1'b0;
    logic [1:0] full_scale = FS_2G;
    logic nvm_ack = 1'b0;
    logic [TRIM_W-1:0] nvm_data = '0;
    logic uoff_wr = 1'b0;
    logic [2:0] uoff_idx = '0;
    logic [7:0] uoff_data = '0;
    logic send = 1'b0;
    logic [41:0] sample = {14'h0300, 14'h3E00, 14'h0100};
    logic sent, took, adc_clk, adc_valid, adc_ready_q, nvm_rd_q, data_ready_q;
    logic [41:0] adc_data;
    logic [1:0] nvm_addr_q, system_state_field_q;
    logic [23:0] out_msb_q, out_lsb_q;
    logic bus_enable_q, analog_en_q, scl_oe_q;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    logic [15:0] trim_tab [3] = '{16'h0008, 16'hFFF8, 16'h0000};
    logic [15:0] uoff_tab [3] = '{16'h0020, 16'hFFE0, 16'h0000};

    acmof_fe_model fe (.send, .sample, .sent, .took, .adc_clk, .adc_valid, .adc_data,
        .adc_ready_q);
    acmof_core uut (.ref_clk, .sys_rst, .supply_ok_pin, .active_req, .sleep_req, .fast_read,
        .full_scale, .nvm_rd_q, .nvm_addr_q, .nvm_ack, .nvm_data, .uoff_wr, .uoff_idx,
        .uoff_data, .adc_clk, .adc_valid, .adc_data, .adc_ready_q, .out_msb_q, .out_lsb_q,
        .data_ready_q, .system_state_field_q, .bus_enable_q, .analog_en_q, .scl_oe_q);

    // System clock
    always #5 ref_clk = ~ref_clk;
    // Trim store answers each fetch on the next edge
    always @(negedge ref_clk) begin
        nvm_ack <= nvm_rd_q;
        nvm_data <= trim_tab[nvm_addr_q];
    end
    // Hang guard, well above the roughly 1000 cycles needed
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Reference result: offset sum, range shift, 10-bit saturation
    function automatic logic [9:0] fmt(input logic signed [13:0] raw,
        input logic signed [15:0] tr, input logic signed [15:0] uo, input logic [1:0] fs);
        logic signed [17:0] s;
        s = (raw + tr + uo) >>> ((fs == 2'h3) ? SHIFT_8G : fs);
        if (s > 18'sh001FF) return 10'h1FF;
        if (s < -18'sh00200) return 10'h200;
        return s[9:0];
    endfunction

    task automatic check_out(input logic [1:0] fs, input logic fr, input logic uo_on);
        logic [23:0] em, el;
        logic [9:0] v;
        for (int a = 0; a < 3; a++) begin
            v = fmt(sample[a*14 +: 14], trim_tab[a], uo_on ? uoff_tab[a] : 16'h0000, fs);
            em[a*8 +: 8] = v[9:2];
            el[a*8 +: 8] = fr ? 8'h00 : {v[1:0], 6'h00};
        end
        cmp(out_msb_q, em);
        cmp(out_lsb_q, el);
        cmp(data_ready_q, 1'b1);
    endtask

    // Offer one frame and wait for the front end to finish it
    task automatic push(input logic [1:0] fs, input logic fr);
        int n;
        full_scale = fs;
        fast_read = fr;
        send = 1'b1;
        n = 0;
        while (sent !== 1'b1 && n < 1000) begin
            tick(1);
            n++;
        end
        cmp(sent, 1'b1);
        send = 1'b0;
        tick(3);
    endtask

    task automatic power_up();
        int n;
        supply_ok_pin = 1'b1;
        n = 0;
        while (bus_enable_q !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        cmp(bus_enable_q, 1'b1);
        cmp({nvm_rd_q, system_state_field_q, scl_oe_q}, {1'b0, SYSF_STBY, 1'b0});
    endtask

    task automatic t_boot();
        cmp({system_state_field_q, bus_enable_q, analog_en_q, scl_oe_q}, 5'h00);
        // Offset write while off must be lost
        uoff_wr = 1'b1;
        uoff_idx = 3'h5;
        uoff_data = 8'h7F;
        tick(1);
        uoff_wr = 1'b0;
        power_up();
        cmp(analog_en_q, 1'b0);
        $display("test boot done");
    endtask

    task automatic t_offsets();
        // Back-to-back writes; index 5 skipped, index 6 out of range
        uoff_wr = 1'b1;
        for (int i = 0; i < 7; i++) begin
            if (i != 5) begin
                uoff_idx = i[2:0];
                uoff_data = (i < 6) ? uoff_tab[i / 2][(i % 2) * 8 +: 8] : 8'hFF;
                tick(1);
            end
        end
        uoff_wr = 1'b0;
        push(FS_2G, 1'b0);
        cmp({took, out_msb_q, data_ready_q}, 26'h0);
        $display("test offsets and standby done");
    endtask

    task automatic t_ranges();
        active_req = 1'b1;
        tick(2);
        cmp({system_state_field_q, analog_en_q, bus_enable_q}, {SYSF_WAKE, 2'b11});
        for (int f = 0; f < 4; f++) begin
            push(f[1:0], 1'b0);
            check_out(f[1:0], 1'b0, 1'b1);
        end
        push(FS_2G, 1'b1);
        check_out(FS_2G, 1'b1, 1'b1);
        push(FS_4G, 1'b0);
        check_out(FS_4G, 1'b0, 1'b1);
        $display("test ranges done");
    endtask

    task automatic t_modes();
        sleep_req = 1'b1;
        tick(2);
        cmp({system_state_field_q, analog_en_q, bus_enable_q}, {SYSF_SLEEP, 2'b11});
        push(FS_8G, 1'b0);
        check_out(FS_8G, 1'b0, 1'b1);
        sleep_req = 1'b0;
        tick(2);
        cmp(system_state_field_q, SYSF_WAKE);
        active_req = 1'b0;
        tick(2);
        cmp({system_state_field_q, analog_en_q}, {SYSF_STBY, 1'b0});
        check_out(FS_8G, 1'b0, 1'b1);
        active_req = 1'b1;
        tick(2);
        cmp({out_msb_q, out_lsb_q, data_ready_q}, 49'h0);
        $display("test modes done");
    endtask

    task automatic t_off();
        supply_ok_pin = 1'b0;
        tick(4);
        cmp({system_state_field_q, bus_enable_q, analog_en_q, scl_oe_q}, 5'h00);
        power_up();
        tick(3);
        push(FS_2G, 1'b0);
        check_out(FS_2G, 1'b0, 1'b0);
        $display("test supply loss done");
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        tick(2);
        t_boot();
        t_offsets();
        t_ranges();
        t_modes();
        t_off();
        stop_test();
    end
endmodule // test_accel_mode_and_output_format
`default_nettype wire
